//--- src/svcp_pkg.sv
// constants for the vendor control mode pages block
package svcp_pkg;
  // page codes and lengths as returned by mode sense
  localparam logic [7:0] SVCP_VCTL_PAGE_CODE  = 8'h37;
  localparam logic [7:0] SVCP_VCTL_PAGE_LEN   = 8'h0E;
  localparam logic [7:0] SVCP_DCTL_PAGE_CODE  = 8'h39;
  localparam logic [7:0] SVCP_DCTL_PAGE_LEN   = 8'h06;
  localparam logic [7:0] SVCP_CACHE_PAGE_CODE = 8'h08;
  // byte offsets inside a page
  localparam logic [3:0] SVCP_OFS_CODE  = 4'h0;
  localparam logic [3:0] SVCP_OFS_LEN   = 4'h1;
  localparam logic [3:0] SVCP_OFS_FLAGS = 4'h2;
  localparam logic [3:0] SVCP_OFS_CTL3  = 4'h3;
  // vendor control page, byte 2
  localparam int SVCP_B_KEEP_SYNC   = 5;
  localparam int SVCP_B_TGT_SYNC    = 4;
  localparam int SVCP_B_PREFETCH    = 1;
  localparam int SVCP_B_CACHE_EN    = 0;
  // drive control page, byte 2
  localparam int SVCP_B_SKIP_ID_OUT = 7;
  localparam int SVCP_B_SKIP_ID_IN  = 6;
  localparam int SVCP_B_FAST_BSY    = 5;
  localparam int SVCP_B_REALLOC_UNC = 4;
  localparam int SVCP_B_FILL_EN     = 3;
  localparam int SVCP_B_NO_UA       = 1;
  localparam int SVCP_B_NO_RESEL_TO = 0;
  // drive control page, byte 3
  localparam int SVCP_B_NO_DISC     = 7;
  localparam int SVCP_B_DISC_DELAY  = 6;
  localparam int SVCP_B_NO_PARITY   = 4;
  localparam int SVCP_B_SOFT_ID_SEL = 3;
  // writable masks; reserved bits always read zero
  localparam logic [7:0] SVCP_VCTL_B2_MASK = 8'h33;
  localparam logic [7:0] SVCP_DCTL_B2_MASK = 8'hFB;
  localparam logic [7:0] SVCP_DCTL_B3_MASK = 8'hDF;
  // reset values and the largest segment count
  localparam logic [7:0] SVCP_VCTL_B2_RST  = 8'h03;
  localparam logic [7:0] SVCP_SEG_RST      = 8'h01;
  localparam logic [7:0] SVCP_SEG_MAX      = 8'h02;
  localparam logic [7:0] SVCP_DCTL_B2_RST  = 8'h08;
  localparam logic [7:0] SVCP_DCTL_B3_RST  = 8'h00;
  // sense values
  localparam logic [3:0] SVCP_SK_MEDIUM    = 4'h3;
  localparam logic [3:0] SVCP_SK_ILLEGAL   = 4'h5;
  localparam logic [7:0] SVCP_ASC_UNRECOV  = 8'h11;
  // sync table
  localparam int SVCP_N_INIT = 8;
  // reselection timeout
  localparam int  SVCP_CLK_HZ       = 50_000_000;
  localparam int  SVCP_RESEL_TO_MS  = 250;
  localparam int  SVCP_RESEL_CYCLES = SVCP_CLK_HZ / 1000 * SVCP_RESEL_TO_MS;
endpackage : svcp_pkg

//--- src/svcp_vendor_pages.sv
// vendor control and drive control mode pages with their control outputs
// How it works
// R1: keep sync table on reset when set
// R2: target sends sync request when set
// R3: cache bits mirror cache page copy
// R4: prefetch only while enabled and caching on
// R5: cache enable governs read caching
// R6: read cache disable zero sets both
// R7: segment count only 1 or 2
// R8: skip identify out lifts identify need
// R9: skip identify in suppresses reconnect identify
// R10: reallocate uncorrectable, later read reports 3/11
// R11: no realloc gives medium error check
// R12: fill pattern written on format when enabled
// R13: fill pattern enable resets to one
// R14: unit attention after resets unless suppressed
// R15: release bus after 250 ms reselect
// R16: no disconnect limits disconnection points
// R17: parity check disable stops checking only
// R18: bus id from jumpers or soft field
// R19: soft id applies at once and at boot
// R20: initiator writes reserved bit as zero
// R21: legacy bits stored, no effect
// R22: cleared table means asynchronous transfers
`timescale 1ns/1ps
module svcp_vendor_pages
  import svcp_pkg::*;
#(
  parameter int unsigned RESEL_CYCLES = SVCP_RESEL_CYCLES
) (
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // mode select byte write
  input  wire logic       i_ms_wr,
  input  wire logic [7:0] i_ms_page,
  input  wire logic [3:0] i_ms_byte,
  input  wire logic [7:0] i_ms_wdata,
  // mode sense byte read
  input  wire logic [7:0] i_sense_page,
  input  wire logic [3:0] i_sense_byte,
  output logic      [7:0] o_sense_data,
  // rejected mode select parameter
  output logic            o_check_illegal,
  // resets seen by the target
  input  wire logic       i_bus_dev_reset,
  input  wire logic       i_hard_reset,
  input  wire logic       i_ua_clear,
  output logic            o_unit_attention,
  // saved drive control byte 3 restored at power on
  input  wire logic       i_saved_load,
  input  wire logic [7:0] i_saved_b3,
  // bus id
  input  wire logic [2:0] i_hw_id,
  output logic      [2:0] o_bus_id,
  // synchronous parameter table
  input  wire logic       i_sync_wr,
  input  wire logic [2:0] i_sync_init,
  input  wire logic [7:0] i_sync_period,
  input  wire logic [7:0] i_sync_offset,
  input  wire logic [2:0] i_sync_rd_init,
  output logic      [7:0] o_sync_period,
  output logic      [7:0] o_sync_offset,
  output logic            o_sync_async,
  output logic            o_send_sdtr,
  // cache control
  output logic            o_cache_en,
  output logic            o_prefetch_en,
  output logic            o_read_cache_disable,
  output logic      [7:0] o_cache_segments,
  // identify, disconnect and parity
  output logic            o_need_identify_out,
  output logic            o_send_identify_in,
  input  wire logic       i_read_seek,
  input  wire logic       i_write_buffered,
  output logic            o_disconnect_ok,
  output logic            o_parity_check_en,
  // uncorrectable error handling
  input  wire logic       i_auto_read_realloc,
  input  wire logic       i_uncorr_err,
  output logic            o_realloc_req,
  output logic            o_medium_err,
  output logic      [3:0] o_sense_key,
  output logic      [7:0] o_sense_code,
  // format fill pattern
  input  wire logic       i_format_start,
  input  wire logic [7:0] i_format_pattern,
  output logic            o_fill_apply,
  output logic      [7:0] o_fill_byte,
  // reselection watchdog
  input  wire logic       i_resel_start,
  input  wire logic       i_bsy_seen,
  output logic            o_resel_release
);

  // stored page bytes, sync table and watchdog state
  logic [7:0] vctl_b2_q;
  logic [7:0] seg_q;
  logic [7:0] dctl_b2_q;
  logic [7:0] dctl_b3_q;
  logic [7:0] sync_per_q [SVCP_N_INIT];
  logic [7:0] sync_ofs_q [SVCP_N_INIT];
  logic       sync_vld_q [SVCP_N_INIT];
  logic       ua_q;
  logic       resel_busy_q;
  logic [31:0] resel_cnt_q;
  logic       tgt_reset;
  logic       wr_vctl_b2;
  logic       wr_vctl_b3;
  logic       wr_dctl_b2;
  logic       wr_dctl_b3;
  logic       wr_cache_pg;
  logic       seg_ok;
  logic [7:0] vctl_b2_d;

  // decode of the page byte being written
  // bytes other than 2 and 3 match no decode and are dropped
  // target resets of either kind act alike on attention and table
  assign tgt_reset  = i_bus_dev_reset | i_hard_reset;
  assign wr_vctl_b2 = i_ms_wr && i_ms_page == SVCP_VCTL_PAGE_CODE
                      && i_ms_byte == SVCP_OFS_FLAGS;
  assign wr_vctl_b3 = i_ms_wr && i_ms_page == SVCP_VCTL_PAGE_CODE
                      && i_ms_byte == SVCP_OFS_CTL3;
  assign wr_dctl_b2 = i_ms_wr && i_ms_page == SVCP_DCTL_PAGE_CODE
                      && i_ms_byte == SVCP_OFS_FLAGS;
  assign wr_dctl_b3 = i_ms_wr && i_ms_page == SVCP_DCTL_PAGE_CODE
                      && i_ms_byte == SVCP_OFS_CTL3;
  // the cache page shares its read cache disable bit with cache enable
  assign wr_cache_pg = i_ms_wr && i_ms_page == SVCP_CACHE_PAGE_CODE
                      && i_ms_byte == SVCP_OFS_FLAGS;   // R3
  assign seg_ok     = i_ms_wdata == SVCP_SEG_RST
                      || i_ms_wdata == SVCP_SEG_MAX;    // R7

  // next value of the cache flag byte from either page
  // one next value keeps the two pages from fighting over the bits
  always_comb begin
    vctl_b2_d = vctl_b2_q;
    if (wr_vctl_b2) begin
      vctl_b2_d = i_ms_wdata & SVCP_VCTL_B2_MASK;
      // prefetch cannot stand without cache enable
      vctl_b2_d[SVCP_B_PREFETCH] = i_ms_wdata[SVCP_B_PREFETCH]
                                   & i_ms_wdata[SVCP_B_CACHE_EN]; // R4
    end else if (wr_cache_pg) begin
      // bit 0 of the cache page byte is the read cache disable copy
      if (!i_ms_wdata[0]) begin
        vctl_b2_d[SVCP_B_CACHE_EN] = 1'b1;              // R6
        vctl_b2_d[SVCP_B_PREFETCH] = 1'b1;              // R6
      end else begin
        vctl_b2_d[SVCP_B_CACHE_EN] = 1'b0;              // R3
        vctl_b2_d[SVCP_B_PREFETCH] = 1'b0;              // R4
      end
    end
  end

  // vendor control page storage
  // a refused segment count leaves the stored one in place
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      vctl_b2_q <= SVCP_VCTL_B2_RST;                    // R5
      seg_q     <= SVCP_SEG_RST;                        // R7
    end else begin
      vctl_b2_q <= vctl_b2_d;
      if (wr_vctl_b3 && seg_ok) begin
        seg_q <= i_ms_wdata;                            // R7
      end
    end
  end

  // drive control page storage; legacy bits kept only for readback
  // saved load only replaces byte 3, so a byte 2 write still lands
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      dctl_b2_q <= SVCP_DCTL_B2_RST;                    // R13
      dctl_b3_q <= SVCP_DCTL_B3_RST;
    end else begin
      if (wr_dctl_b2) begin
        // reserved bit is masked even if the initiator sets it
        dctl_b2_q <= i_ms_wdata & SVCP_DCTL_B2_MASK;    // R20 R21
      end
      if (i_saved_load) begin
        dctl_b3_q <= i_saved_b3 & SVCP_DCTL_B3_MASK;    // R19
      end else if (wr_dctl_b3) begin
        dctl_b3_q <= i_ms_wdata & SVCP_DCTL_B3_MASK;    // R19 R21
      end
    end
  end

  // bad segment count answers with a one-cycle illegal request pulse
  // the command layer turns the pulse into check condition status
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_check_illegal <= 1'b0;
    end else begin
      o_check_illegal <= wr_vctl_b3 && !seg_ok;         // R7
    end
  end

  // mode sense readback, registered
  // unknown pages and bytes read zero, as reserved fields must
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_sense_data <= 8'h00;
    end else begin
      o_sense_data <= 8'h00;
      if (i_sense_page == SVCP_VCTL_PAGE_CODE) begin
        case (i_sense_byte)
          SVCP_OFS_CODE:  o_sense_data <= SVCP_VCTL_PAGE_CODE;
          SVCP_OFS_LEN:   o_sense_data <= SVCP_VCTL_PAGE_LEN;
          SVCP_OFS_FLAGS: o_sense_data <= vctl_b2_q;
          SVCP_OFS_CTL3:  o_sense_data <= seg_q;
          default:        o_sense_data <= 8'h00;
        endcase
      end else if (i_sense_page == SVCP_DCTL_PAGE_CODE) begin
        case (i_sense_byte)
          SVCP_OFS_CODE:  o_sense_data <= SVCP_DCTL_PAGE_CODE;
          SVCP_OFS_LEN:   o_sense_data <= SVCP_DCTL_PAGE_LEN;
          SVCP_OFS_FLAGS: o_sense_data <= dctl_b2_q;    // R21
          SVCP_OFS_CTL3:  o_sense_data <= dctl_b3_q;    // R21
          default:        o_sense_data <= 8'h00;
        endcase
      end
    end
  end

  // unit attention; a new reset wins over a clear in the same cycle
  // power on always raises it; the suppress bit is not consulted at reset
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_unit_attention <= 1'b1;                         // R14
    end else if (tgt_reset && !dctl_b2_q[SVCP_B_NO_UA]) begin
      o_unit_attention <= 1'b1;                         // R14
    end else if (i_ua_clear) begin
      o_unit_attention <= 1'b0;
    end
  end

  // per-initiator sync table; power on always clears it
  // target resets honour the keep bit; a clear beats a same-cycle write
  for (genvar g = 0; g < SVCP_N_INIT; g++) begin : g_sync
    always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
        sync_vld_q[g] <= 1'b0;
        sync_per_q[g] <= 8'h00;
        sync_ofs_q[g] <= 8'h00;
      end else if (tgt_reset && !vctl_b2_q[SVCP_B_KEEP_SYNC]) begin
        sync_vld_q[g] <= 1'b0;                          // R1 R22
        sync_per_q[g] <= 8'h00;                         // R1
        sync_ofs_q[g] <= 8'h00;                         // R1
      end else if (i_sync_wr && i_sync_init == 3'(g)) begin
        sync_vld_q[g] <= 1'b1;
        sync_per_q[g] <= i_sync_period;
        sync_ofs_q[g] <= i_sync_offset;
      end
    end
  end

  // table lookup; an empty entry means asynchronous transfers
  // one cycle of latency, so the caller holds the index steady
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_sync_period <= 8'h00;
      o_sync_offset <= 8'h00;
      o_sync_async  <= 1'b1;
    end else begin
      o_sync_period <= sync_per_q[i_sync_rd_init];
      o_sync_offset <= sync_ofs_q[i_sync_rd_init];
      o_sync_async  <= !sync_vld_q[i_sync_rd_init];     // R22
    end
  end

  // control levels decoded from the pages
  // registered so a page write never glitches the bus side controls
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_send_sdtr          <= 1'b0;
      o_cache_en           <= 1'b1;
      o_prefetch_en        <= 1'b1;
      o_read_cache_disable <= 1'b0;
      o_cache_segments     <= SVCP_SEG_RST;
      o_need_identify_out  <= 1'b1;
      o_send_identify_in   <= 1'b1;
      o_parity_check_en    <= 1'b1;
      o_bus_id             <= 3'h0;
    end else begin
      o_send_sdtr          <= vctl_b2_q[SVCP_B_TGT_SYNC];       // R2
      o_cache_en           <= vctl_b2_q[SVCP_B_CACHE_EN];       // R5
      o_prefetch_en        <= vctl_b2_q[SVCP_B_PREFETCH]
                              & vctl_b2_q[SVCP_B_CACHE_EN];     // R4
      o_read_cache_disable <= !vctl_b2_q[SVCP_B_CACHE_EN];      // R3 R6
      o_cache_segments     <= seg_q;
      o_need_identify_out  <= !dctl_b2_q[SVCP_B_SKIP_ID_OUT];   // R8
      o_send_identify_in   <= !dctl_b2_q[SVCP_B_SKIP_ID_IN];    // R9
      o_parity_check_en    <= !dctl_b3_q[SVCP_B_NO_PARITY];     // R17
      // soft id follows the stored byte, so a write lands at once
      o_bus_id <= dctl_b3_q[SVCP_B_SOFT_ID_SEL] ? dctl_b3_q[2:0]
                                                 : i_hw_id;    // R18 R19
    end
  end

  // disconnect permission for the current phase
  // seek and buffered flags are levels from the command sequencer
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_disconnect_ok <= 1'b1;
    end else begin
      o_disconnect_ok <= !dctl_b3_q[SVCP_B_NO_DISC]
                         || i_read_seek || i_write_buffered;   // R16
    end
  end

  // uncorrectable error: reallocate or report a medium error
  // sense values hold until the next event so the host can fetch them
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_realloc_req <= 1'b0;
      o_medium_err  <= 1'b0;
      o_sense_key   <= 4'h0;
      o_sense_code  <= 8'h00;
    end else begin
      o_realloc_req <= 1'b0;
      o_medium_err  <= 1'b0;
      if (i_uncorr_err) begin
        if (dctl_b2_q[SVCP_B_REALLOC_UNC] && i_auto_read_realloc) begin
          o_realloc_req <= 1'b1;                        // R10
        end else begin
          o_medium_err  <= 1'b1;                        // R11
        end
        o_sense_key  <= SVCP_SK_MEDIUM;                 // R10 R11
        o_sense_code <= SVCP_ASC_UNRECOV;               // R10
      end else if (o_check_illegal) begin
        o_sense_key  <= SVCP_SK_ILLEGAL;                // R7
        o_sense_code <= 8'h00;
      end
    end
  end

  // format fill pattern, captured at the start of a format
  // outputs hold for the whole format; zero pattern when disabled
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_fill_apply <= 1'b0;
      o_fill_byte  <= 8'h00;
    end else if (i_format_start) begin
      o_fill_apply <= dctl_b2_q[SVCP_B_FILL_EN];        // R12
      o_fill_byte  <= dctl_b2_q[SVCP_B_FILL_EN] ? i_format_pattern
                                                : 8'h00; // R12
    end
  end

  // reselection watchdog; counter is wide since 250 ms is millions of cycles
  // a busy response or the disable bit ends the watch with no release
  // the release pulse lasts one cycle; the bus side must act on it at once
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      resel_busy_q    <= 1'b0;
      resel_cnt_q     <= 32'h0000_0000;
      o_resel_release <= 1'b0;
    end else begin
      o_resel_release <= 1'b0;
      if (i_resel_start) begin
        resel_busy_q <= !dctl_b2_q[SVCP_B_NO_RESEL_TO]; // R15
        resel_cnt_q  <= 32'h0000_0000;
      end else if (resel_busy_q) begin
        if (i_bsy_seen) begin
          resel_busy_q <= 1'b0;
        end else if (resel_cnt_q == 32'(RESEL_CYCLES - 1)) begin
          resel_busy_q    <= 1'b0;
          o_resel_release <= 1'b1;                      // R15
        end else begin
          resel_cnt_q <= resel_cnt_q + 32'h0000_0001;
        end
      end
    end
  end

endmodule : svcp_vendor_pages

//--- test/scsi_vendor_control_pages_test.sv
// self-checking bench for the vendor control pages block
`timescale 1ns/1ps
module scsi_vendor_control_pages_test
  import svcp_pkg::*;
;
  localparam int         RC = 20;
  localparam logic [7:0] PV = SVCP_VCTL_PAGE_CODE;
  localparam logic [7:0] PD = SVCP_DCTL_PAGE_CODE;
  logic       i_clk = 0, i_nrst = 0, i_bus_dev_reset = 0, i_hard_reset = 0;
  logic       i_ua_clear = 0, i_saved_load = 0, i_sync_wr = 0;
  logic       i_uncorr_err = 0, i_format_start = 0, i_resel_start = 0;
  logic       i_bsy_seen = 0, i_read_seek = 0, i_write_buffered = 0;
  logic       i_auto_read_realloc = 0;
  logic       i_ms_wr, o_check_illegal, o_unit_attention, o_sync_async;
  logic       o_send_sdtr, o_cache_en, o_prefetch_en, o_read_cache_disable;
  logic       o_need_identify_out, o_send_identify_in, o_disconnect_ok;
  logic       o_parity_check_en, o_realloc_req, o_medium_err, o_fill_apply;
  logic       o_resel_release;
  logic [2:0] i_hw_id = 0, i_sync_init = 0, i_sync_rd_init = 0, o_bus_id;
  logic [3:0] i_ms_byte, i_sense_byte = 0, o_sense_key;
  logic [7:0] i_ms_page, i_ms_wdata, i_sense_page = 0, o_sense_data;
  logic [7:0] i_saved_b3 = 0, i_sync_period = 0, i_sync_offset = 0;
  logic [7:0] o_sync_period, o_sync_offset, o_cache_segments, o_sense_code;
  logic [7:0] i_format_pattern = 0, o_fill_byte;
  logic [7:0] v2 = 8'h03, sg = 8'h01, d2 = 8'h08, d3 = 8'h00;
  int         fails = 0, checks = 0, n;
  // clock at 50 MHz
  always #10 i_clk = ~i_clk;
  svcp_vendor_pages #(.RESEL_CYCLES(RC)) svcp_vendor_pages_inst (.*);
  svcp_initiator_model svcp_initiator_model_inst (
    .i_clk(i_clk), .o_wr(i_ms_wr), .o_page(i_ms_page),
    .o_byte(i_ms_byte), .o_data(i_ms_wdata));
  task automatic cy(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask : cy
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rd(input logic [7:0] p, input logic [3:0] b,
                    input logic [7:0] e);
    i_sense_page = p;
    i_sense_byte = b;
    cy(2);
    chk(o_sense_data, e);
  endtask : rd
  // write one byte and keep the reference pages in step
  task automatic wr(input logic [7:0] p, input logic [3:0] b,
                    input logic [7:0] v);
    logic bad;
    logic g;
    bad = p == PV && b == 4'h3 && !(v inside {8'h01, 8'h02});
    if (p == PV && b == 4'h2) v2 = v & 8'h33 & (v[0] ? 8'hFF : 8'hFD);
    if (p == PV && b == 4'h3 && !bad) sg = v;
    if (p == PD && b == 4'h2) d2 = v & 8'hFB;
    if (p == PD && b == 4'h3) d3 = v & 8'hDF;
    if (p == SVCP_CACHE_PAGE_CODE) v2 = v[0] ? v2 & 8'hFC : v2 | 8'h03;
    svcp_initiator_model_inst.ms_write(p, b, v);
    g = o_check_illegal;
    cy(1);
    g = g | o_check_illegal;
    chk(g, bad);
    if (bad) chk(o_sense_key, SVCP_SK_ILLEGAL);
    cy(2);
  endtask : wr
  task automatic outs;
    chk(o_cache_en, v2[0]);
    chk(o_prefetch_en, v2[1]);
    chk(o_read_cache_disable, !v2[0]);
    chk(o_send_sdtr, v2[4]);
    chk(o_cache_segments, sg);
    chk(o_need_identify_out, !d2[7]);
    chk(o_send_identify_in, !d2[6]);
    chk(o_parity_check_en, !d3[4]);
    chk(o_bus_id, d3[3] ? d3[2:0] : i_hw_id);
    rd(PV, 4'h0, PV);
    rd(PV, 4'h1, SVCP_VCTL_PAGE_LEN);
    rd(PV, 4'h2, v2);
    rd(PV, 4'h3, sg);
    rd(PD, 4'h0, PD);
    rd(PD, 4'h1, SVCP_DCTL_PAGE_LEN);
    rd(PD, 4'h2, d2);
    rd(PD, 4'h3, d3);
  endtask : outs
  task automatic complete_run;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // watchdog well beyond the roughly 800 cycles the tests need
  initial begin
    #200_000;
    fails++;
    complete_run;
  end
  initial begin
    void'($urandom(21));
    cy(5);
    i_nrst = 1;
    cy(1);
    chk(o_unit_attention, 1);
    chk(o_sync_async, 1);
    outs;
    $display("test reset values done");
    wr(PV, 4'h5, 8'hFF);
    for (int i = 0; i < 24; i++) begin
      i_hw_id = 3'($urandom);
      wr(i % 3 == 0 ? PV : i % 3 == 1 ? PD : SVCP_CACHE_PAGE_CODE,
         i % 3 == 2 ? 4'h2 : 4'h2 + 4'((i / 3) % 2),
         8'($urandom) & (i[2] ? 8'hFF : 8'h03));
      outs;
    end
    wr(PD, 4'h3, 8'h0D);
    outs;
    i_saved_b3 = 8'h0A;
    i_saved_load = 1;
    cy(1);
    i_saved_load = 0;
    d3 = 8'h0A;
    cy(3);
    outs;
    $display("test register writes done");
    i_sync_init = 3'h3;
    i_sync_rd_init = 3'h3;
    i_sync_period = 8'h19;
    i_sync_offset = 8'h08;
    for (int k = 0; k < 3; k++) begin
      wr(PV, 4'h2, k != 0 ? 8'h23 : 8'h03);
      wr(PD, 4'h2, k == 2 ? 8'h0A : 8'h08);
      i_sync_wr = 1;
      i_ua_clear = 1;
      cy(1);
      i_sync_wr = 0;
      i_ua_clear = 0;
      cy(2);
      chk(o_sync_period, 8'h19);
      chk(o_sync_offset, 8'h08);
      chk(o_sync_async, 0);
      chk(o_unit_attention, 0);
      i_hard_reset = k != 1;
      i_bus_dev_reset = k == 1;
      cy(1);
      i_hard_reset = 0;
      i_bus_dev_reset = 0;
      cy(2);
      chk(o_sync_async, k == 0);
      chk(o_sync_offset, k == 0 ? 8'h00 : 8'h08);
      chk(o_unit_attention, k != 2);
    end
    $display("test target resets done");
    for (int k = 0; k < 3; k++) begin
      wr(PD, 4'h2, k == 2 ? 8'h08 : 8'h18);
      i_auto_read_realloc = k == 0;
      i_uncorr_err = 1;
      cy(1);
      i_uncorr_err = 0;
      chk(o_realloc_req, k == 0);
      chk(o_medium_err, k != 0);
      chk(o_sense_key, SVCP_SK_MEDIUM);
      chk(o_sense_code, SVCP_ASC_UNRECOV);
    end
    $display("test uncorrectable errors done");
    for (int k = 0; k < 2; k++) begin
      wr(PD, 4'h2, k != 0 ? 8'h00 : 8'h08);
      i_format_pattern = 8'($urandom);
      i_format_start = 1;
      cy(1);
      i_format_start = 0;
      cy(1);
      chk(o_fill_apply, k == 0);
      if (k == 0) chk(o_fill_byte, i_format_pattern);
    end
    $display("test format fill done");
    for (int k = 0; k < 3; k++) begin
      wr(PD, 4'h2, k == 2 ? 8'h01 : 8'h00);
      i_bsy_seen = k == 1;
      i_resel_start = 1;
      cy(1);
      i_resel_start = 0;
      n = 0;
      repeat (RC + 10) begin
        cy(1);
        if (o_resel_release === 1'b1) n++;
      end
      chk(8'(n), k == 0);
    end
    i_bsy_seen = 0;
    $display("test reselection done");
    for (int j = 0; j < 8; j++) begin
      if (j % 4 == 0) wr(PD, 4'h3, j[2] ? 8'h80 : 8'h00);
      i_read_seek = j[0];
      i_write_buffered = j[1];
      cy(2);
      chk(o_disconnect_ok, !j[2] || j[0] || j[1]);
    end
    $display("test disconnection done");
    complete_run;
  end
endmodule : scsi_vendor_control_pages_test

//--- test/svcp_initiator_model.sv
// initiator model that issues mode select byte writes
`timescale 1ns/1ps
module svcp_initiator_model
  import svcp_pkg::*;
(
  input  wire logic       i_clk,
  output logic            o_wr,
  output logic      [7:0] o_page,
  output logic      [3:0] o_byte,
  output logic      [7:0] o_data
);
  // idle lines start low
  initial begin
    o_wr = 1'b0;
    o_page = 8'h00;
    o_byte = 4'h0;
    o_data = 8'h00;
  end
  // one byte per write; idle lines invert so stale data is never reused
  task automatic ms_write(input logic [7:0] p, input logic [3:0] b,
                          input logic [7:0] v);
    @(posedge i_clk);
    #1;
    o_page = p;
    o_byte = b;
    o_data = (p == SVCP_DCTL_PAGE_CODE && b == 4'h2) ? v & 8'hFB : v;
    o_wr = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    o_page = ~p;
    o_byte = ~b;
    o_data = ~o_data;
  endtask : ms_write
endmodule : svcp_initiator_model

//--- test/svcp_vendor_pages_props.sv
// assertions on the vendor control pages ports
`timescale 1ns/1ps
module svcp_vendor_pages_props
  import svcp_pkg::*;
#(
  parameter int unsigned RESEL_CYCLES = SVCP_RESEL_CYCLES
) (
  input wire logic       i_clk,
  input wire logic       i_nrst,
  input wire logic       i_ms_wr,
  input wire logic [7:0] i_ms_page,
  input wire logic [3:0] i_ms_byte,
  input wire logic [7:0] i_ms_wdata,
  input wire logic       o_check_illegal,
  input wire logic       i_bus_dev_reset,
  input wire logic       i_hard_reset,
  input wire logic       o_unit_attention,
  input wire logic       o_cache_en,
  input wire logic       o_prefetch_en,
  input wire logic       o_read_cache_disable,
  input wire logic [7:0] o_cache_segments,
  input wire logic       i_auto_read_realloc,
  input wire logic       i_uncorr_err,
  input wire logic       o_realloc_req,
  input wire logic       o_medium_err,
  input wire logic [3:0] o_sense_key,
  input wire logic [7:0] o_sense_code,
  input wire logic       i_format_start,
  input wire logic       o_fill_apply,
  input wire logic       i_resel_start,
  input wire logic       o_resel_release
);
  logic        seg_wr;
  logic        seg_ok;
  logic [31:0] resel_q;
  logic        flag_wr;
  logic        cpage_wr;
  // segment count writes and the two values accepted
  assign seg_wr = i_ms_wr && i_ms_page == SVCP_VCTL_PAGE_CODE
                  && i_ms_byte == SVCP_OFS_CTL3;
  assign seg_ok = i_ms_wdata == SVCP_SEG_RST || i_ms_wdata == SVCP_SEG_MAX;
  // byte 2 writes that move the cache bits, from either page
  assign flag_wr  = i_ms_wr && i_ms_page == SVCP_VCTL_PAGE_CODE
                    && i_ms_byte == SVCP_OFS_FLAGS;
  assign cpage_wr = i_ms_wr && i_ms_page == SVCP_CACHE_PAGE_CODE
                    && i_ms_byte == SVCP_OFS_FLAGS;
  // cycles since reselection began; saturates so it never wraps
  always_ff @(posedge i_clk) begin
    if (!i_nrst || i_resel_start) begin
      resel_q <= '0;
    end else if (resel_q < RESEL_CYCLES + 8) begin
      resel_q <= resel_q + 1;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  seg_reject_a: assert property (
    seg_wr && !seg_ok |-> ##[1:2] o_check_illegal)
    else $error("segment refusal missing");
  seg_accept_a: assert property (
    seg_wr && seg_ok |-> ##3 o_cache_segments == $past(i_ms_wdata, 3))
    else $error("segment count not applied");
  prefetch_cache_a: assert property (
    flag_wr && !i_ms_wdata[SVCP_B_CACHE_EN] |-> ##2 !o_prefetch_en)
    else $error("prefetch without cache");
  cache_mirror_a: assert property (
    cpage_wr && !i_ms_wdata[0] |-> ##2 o_cache_en && o_prefetch_en
                                   && !o_read_cache_disable)
    else $error("cache page write not mirrored");
  uncorr_one_a: assert property (
    i_uncorr_err |=> o_realloc_req != o_medium_err)
    else $error("uncorrectable error handled twice or not");
  realloc_cause_a: assert property (
    o_realloc_req |-> $past(i_auto_read_realloc))
    else $error("realloc without read reallocation");
  medium_sense_a: assert property (
    o_medium_err |-> o_sense_key == SVCP_SK_MEDIUM
                     && o_sense_code == SVCP_ASC_UNRECOV)
    else $error("medium error sense wrong");
  ua_cause_a: assert property (
    $rose(o_unit_attention) |-> $past(i_hard_reset || i_bus_dev_reset))
    else $error("attention without reset");
  fill_cause_a: assert property (
    $rose(o_fill_apply) |-> $past(i_format_start))
    else $error("fill without format");
  resel_time_a: assert property (
    o_resel_release |-> resel_q >= RESEL_CYCLES - 2
                        && resel_q <= RESEL_CYCLES + 2)
    else $error("release at wrong time");
  cover property (o_realloc_req);
  cover property (o_resel_release);
  cover property (seg_wr && !seg_ok);
endmodule : svcp_vendor_pages_props
bind svcp_vendor_pages svcp_vendor_pages_props #(
  .RESEL_CYCLES(RESEL_CYCLES)
) svcp_vendor_pages_props_inst (.*);
